/* src/led0_consts.svh */
`ifndef LED0_CONSTS_SVH
`define LED0_CONSTS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define LED0_CTRL_OFFSET 16'h40C0
`define LED0_STATUS_OFFSET 16'h40C4
`define LED0_CTRL_RESET 16'h0311
`define LED0_ADDR_W 16

// ----------------------------------------
// status register field positions
// ----------------------------------------
`define LED0_ST_LED_BIT 0
`define LED0_ST_BLINK_BIT 1
`define LED0_ST_HOLD_BIT 2
`define LED0_ST_LINK_BIT 3
`define LED0_ST_FORCE_BIT 4

// ----------------------------------------
// forced-state codes
// ----------------------------------------
`define LED_FORCE_OFF 2'h0
`define LED_FORCE_ON 2'h1
`define LED_FORCE_BLINK_ONE 2'h2
`define LED_FORCE_BLINK_TWO 2'h3

// ----------------------------------------
// bus answers
// ----------------------------------------
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define LED_HOLD_NS 10000000
`define HOLD_CNT_W 22

`endif

/* src/led0_pkg.sv */
package led0_pkg;

  // control register layout, bit 15 first
  typedef struct packed {
    logic led_force_enable;
    logic [1:0] led_forced_state;
    logic activity_blink_indication;
    logic full_duplex_on_enable;
    logic half_duplex_on_enable;
    logic tx_activity_blink_enable;
    logic rx_activity_blink_enable;
    logic tx_activity_on_enable;
    logic rx_activity_on_enable;
    logic fast_speed_on_enable;
    logic slow_speed_on_enable;
    logic collision_blink_enable;
    logic fast_speed_blink_enable;
    logic slow_speed_blink_enable;
    logic link_check_indication;
  } led0_ctrl_t;

  // status from the phy logic, same clock
  typedef struct packed {
    logic phy_active;
    logic link_check_state;
    logic link_up;
    logic speed_fast;
    logic full_duplex;
    logic tx_active;
    logic rx_active;
    logic collision;
  } phy_status_t;

  // blink waveforms from the shared rate generator
  typedef struct packed {
    logic blink_timebase_one;
    logic blink_timebase_two;
  } blink_wave_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } rd_state_t;

endpackage

/* src/status_led0_controller.sv */
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "led0_consts.svh"

module status_led0_controller #(
  parameter int unsigned HOLD_CYCLES = (`LED_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire led0_pkg::phy_status_t phy,
  input wire led0_pkg::blink_wave_t wave,
  output logic led_on,
  input wire logic awvalid,
  output logic awready,
  input wire logic [15:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [15:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import led0_pkg::*;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  localparam logic [`HOLD_CNT_W-1:0] HOLD_LOAD = HOLD_CYCLES[`HOLD_CNT_W-1:0];

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  led0_ctrl_t ctrl_r, ctrl_nxt;
  logic [`HOLD_CNT_W-1:0] hold_cnt_r, hold_cnt_nxt;
  logic led_r, led_nxt;
  logic blink_seen_r, blink_seen_nxt;
  logic steady_on, act_blink, blink_two, blink_one, blink_any;
  logic hold_on, hold_load, link_check;

  wr_state_t wr_state_r, wr_state_nxt;
  logic have_aw_r, have_aw_nxt;
  logic have_w_r, have_w_nxt;
  logic [15:0] wr_addr_r, wr_addr_nxt;
  logic [15:0] wr_data_r, wr_data_nxt;
  logic [1:0] wr_strb_r, wr_strb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;

  rd_state_t rd_state_r, rd_state_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [15:0] status_word;

  // ----------------------------------------
  // indicator decision
  // ----------------------------------------
  always_comb begin
    link_check = phy.phy_active && phy.link_check_state;
    hold_on = (hold_cnt_r != '0);
    steady_on = phy.link_up && (
      (ctrl_r.full_duplex_on_enable && phy.full_duplex) ||
      (ctrl_r.half_duplex_on_enable && !phy.full_duplex) ||
      (ctrl_r.fast_speed_on_enable && phy.speed_fast) ||
      (ctrl_r.slow_speed_on_enable && !phy.speed_fast) ||
      hold_on);
    act_blink = phy.link_up &&
      ((ctrl_r.tx_activity_blink_enable && phy.tx_active) ||
       (ctrl_r.rx_activity_blink_enable && phy.rx_active)) &&
      (ctrl_r.activity_blink_indication || steady_on);
    blink_two = act_blink ||
      (phy.link_up && ctrl_r.collision_blink_enable && phy.collision);
    blink_one = phy.link_up &&
      ((ctrl_r.fast_speed_blink_enable && phy.speed_fast) ||
       (ctrl_r.slow_speed_blink_enable && !phy.speed_fast));
    blink_any = blink_two || blink_one;
    blink_seen_nxt = blink_any && !ctrl_r.led_force_enable;
    if (ctrl_r.led_force_enable) begin
      unique case (ctrl_r.led_forced_state)
        `LED_FORCE_OFF: led_nxt = 1'b0;
        `LED_FORCE_ON: led_nxt = 1'b1;
        `LED_FORCE_BLINK_ONE: led_nxt = wave.blink_timebase_one;
        `LED_FORCE_BLINK_TWO: led_nxt = wave.blink_timebase_two;
      endcase
    end else if (link_check) begin
      led_nxt = ctrl_r.link_check_indication;
    end else if (blink_two) begin
      led_nxt = wave.blink_timebase_two;
    end else if (blink_one) begin
      led_nxt = wave.blink_timebase_one;
    end else begin
      led_nxt = steady_on;
    end
  end

  // ----------------------------------------
  // activity hold timer
  // ----------------------------------------
  always_comb begin
    hold_load = phy.link_up &&
      ((ctrl_r.tx_activity_on_enable && phy.tx_active) ||
       (ctrl_r.rx_activity_on_enable && phy.rx_active));
    if (hold_load) begin
      hold_cnt_nxt = HOLD_LOAD;
    end else if (hold_on) begin
      hold_cnt_nxt = hold_cnt_r - 1'b1;
    end else begin
      hold_cnt_nxt = hold_cnt_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      led_r <= 1'b0;
      blink_seen_r <= 1'b0;
      hold_cnt_r <= '0;
    end else if (ce) begin
      led_r <= led_nxt;
      blink_seen_r <= blink_seen_nxt;
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  assign led_on = led_r;

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  // address and data are caught separately so either may come first
  always_comb begin
    wr_state_nxt = wr_state_r;
    have_aw_nxt = have_aw_r;
    have_w_nxt = have_w_r;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    wr_strb_nxt = wr_strb_r;
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    ctrl_nxt = ctrl_r;
    unique case (wr_state_r)
      WR_IDLE: begin
        if (awvalid && awready_r) begin
          have_aw_nxt = 1'b1;
          wr_addr_nxt = awaddr;
          awready_nxt = 1'b0;
        end
        if (wvalid && wready_r) begin
          have_w_nxt = 1'b1;
          wr_data_nxt = wdata[15:0];
          wr_strb_nxt = wstrb[1:0];
          wready_nxt = 1'b0;
        end
        if (have_aw_r && have_w_r) begin
          bvalid_nxt = 1'b1;
          wr_state_nxt = WR_RESP;
          if ({wr_addr_r[15:2], 2'h0} == `LED0_CTRL_OFFSET) begin
            bresp_nxt = `AXI_RESP_OKAY;
            if (wr_strb_r[0]) begin
              ctrl_nxt[7:0] = wr_data_r[7:0];
            end
            if (wr_strb_r[1]) begin
              ctrl_nxt[15:8] = wr_data_r[15:8];
            end
          end else if ({wr_addr_r[15:2], 2'h0} == `LED0_STATUS_OFFSET) begin
            bresp_nxt = `AXI_RESP_OKAY;
          end else begin
            bresp_nxt = `AXI_RESP_SLVERR;
          end
        end
      end
      WR_RESP: begin
        if (bready) begin
          bvalid_nxt = 1'b0;
          have_aw_nxt = 1'b0;
          have_w_nxt = 1'b0;
          awready_nxt = 1'b1;
          wready_nxt = 1'b1;
          wr_state_nxt = WR_IDLE;
        end
      end
      default: begin
        wr_state_nxt = WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wr_state_r <= WR_IDLE;
      have_aw_r <= 1'b0;
      have_w_r <= 1'b0;
      wr_addr_r <= 16'h0000;
      wr_data_r <= 16'h0000;
      wr_strb_r <= 2'h0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `AXI_RESP_OKAY;
      ctrl_r <= `LED0_CTRL_RESET;
    end else if (ce) begin
      wr_state_r <= wr_state_nxt;
      have_aw_r <= have_aw_nxt;
      have_w_r <= have_w_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
      wr_strb_r <= wr_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  always_comb begin
    status_word = 16'h0000;
    status_word[`LED0_ST_LED_BIT] = led_r;
    status_word[`LED0_ST_BLINK_BIT] = blink_seen_r;
    status_word[`LED0_ST_HOLD_BIT] = hold_on;
    status_word[`LED0_ST_LINK_BIT] = phy.link_up;
    status_word[`LED0_ST_FORCE_BIT] = ctrl_r.led_force_enable;
    rd_state_nxt = rd_state_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    unique case (rd_state_r)
      RD_IDLE: begin
        if (arvalid && arready_r) begin
          arready_nxt = 1'b0;
          rvalid_nxt = 1'b1;
          rd_state_nxt = RD_DATA;
          if ({araddr[15:2], 2'h0} == `LED0_CTRL_OFFSET) begin
            rdata_nxt = {16'h0000, ctrl_r};
            rresp_nxt = `AXI_RESP_OKAY;
          end else if ({araddr[15:2], 2'h0} == `LED0_STATUS_OFFSET) begin
            rdata_nxt = {16'h0000, status_word};
            rresp_nxt = `AXI_RESP_OKAY;
          end else begin
            rdata_nxt = 32'h0000_0000;
            rresp_nxt = `AXI_RESP_SLVERR;
          end
        end
      end
      RD_DATA: begin
        if (rready) begin
          rvalid_nxt = 1'b0;
          arready_nxt = 1'b1;
          rd_state_nxt = RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_state_r <= RD_IDLE;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `AXI_RESP_OKAY;
    end else if (ce) begin
      rd_state_r <= rd_state_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_force_off_state: assert property (
    ce && ctrl_r.led_force_enable && ctrl_r.led_forced_state == `LED_FORCE_OFF |=> !led_r)
    else $error("forced off but indicator lit");
  chk_force_blink_wave: assert property (
    ce && ctrl_r.led_force_enable && ctrl_r.led_forced_state == `LED_FORCE_BLINK_TWO
    |=> led_r == $past(wave.blink_timebase_two))
    else $error("forced blink does not follow timebase two");
  chk_link_check_level: assert property (
    ce && !ctrl_r.led_force_enable && phy.phy_active && phy.link_check_state
    |=> led_r == $past(ctrl_r.link_check_indication))
    else $error("link check state shows wrong level");
  chk_link_down_dark: assert property (
    ce && !ctrl_r.led_force_enable && !link_check && !phy.link_up |=> !led_r)
    else $error("indicator lit with link down");
  chk_blink_beats_steady: assert property (
    ce && !ctrl_r.led_force_enable && !link_check && blink_two && steady_on
    |=> led_r == $past(wave.blink_timebase_two))
    else $error("steady condition overrode blink");
  chk_fdx_steady_on: assert property (
    ce && !ctrl_r.led_force_enable && !link_check && !blink_any && phy.link_up
    && ctrl_r.full_duplex_on_enable && phy.full_duplex |=> led_r)
    else $error("full duplex link not lit");
  chk_hold_reload: assert property (
    ce && phy.link_up && ctrl_r.tx_activity_on_enable && phy.tx_active
    |=> hold_cnt_r == HOLD_LOAD ##1 (!$past(ce) || $past(hold_load) || hold_cnt_r == HOLD_LOAD - 1'b1))
    else $error("activity hold not loaded to full time");
  chk_act_needs_on: assert property (
    ce && !ctrl_r.led_force_enable && !link_check && !ctrl_r.activity_blink_indication && !steady_on
    && !blink_one && !(phy.link_up && ctrl_r.collision_blink_enable && phy.collision) |=> !led_r)
    else $error("activity blink while dark without indication bit");
  chk_bresp_holds: assert property (
    bvalid_r && !bready |=> bvalid_r && $stable(bresp_r))
    else $error("write answer dropped before taken");
  chk_rdata_holds: assert property (
    rvalid_r && !rready |=> rvalid_r && $stable(rdata_r))
    else $error("read answer changed before taken");

endmodule

/* tb/led_lamp.sv */
`timescale 1ns/1ps
module led_lamp (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic led_on,
  output int run_len,
  output int last_run
);
  // ----------------------------------------
  // lamp: length of each lit spell
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      run_len <= 0;
      last_run <= 0;
    end else if (led_on) begin
      run_len <= run_len + 1;
    end else begin
      if (run_len != 0)
        last_run <= run_len;
      run_len <= 0;
    end
  end
endmodule

/* tb/status_led0_controller_tb.sv */
`timescale 1ns/1ps
`include "led0_consts.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, b); end end
module status_led0_controller_tb;
  import led0_pkg::*;
  // short hold so the activity stretch fits the run
  localparam int unsigned HOLD = 20;
  logic ref_clk = 1'b0, rst_b = 1'b0, ce = 1'b1, led_on;
  phy_status_t phy = '0;
  blink_wave_t wave = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, r;
  logic [15:0] c;
  led0_ctrl_t sh;
  int n_errors = 0, num_checks = 0, run_len, last_run, i, k;

  always #2 ref_clk = ~ref_clk;

  status_led0_controller #(.HOLD_CYCLES(HOLD)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
    .phy(phy), .wave(wave), .led_on(led_on), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp));
  led_lamp lamp_u (.ref_clk(ref_clk), .rst_b(rst_b), .led_on(led_on), .run_len(run_len),
    .last_run(last_run));

  // ----------------------------------------
  // expected indicator from control and status
  // ----------------------------------------
  function automatic logic exp_led(led0_ctrl_t t, phy_status_t p, blink_wave_t w);
    logic st;
    logic act;
    st = t.full_duplex_on_enable & p.full_duplex | t.half_duplex_on_enable & ~p.full_duplex
      | t.fast_speed_on_enable & p.speed_fast | t.slow_speed_on_enable & ~p.speed_fast;
    act = (t.tx_activity_blink_enable & p.tx_active | t.rx_activity_blink_enable & p.rx_active)
      & (t.activity_blink_indication | st);
    if (t.led_force_enable)
      return t.led_forced_state[1] ? (t.led_forced_state[0] ? w.blink_timebase_two
        : w.blink_timebase_one) : t.led_forced_state[0];
    if (p.phy_active & p.link_check_state)
      return t.link_check_indication;
    if (!p.link_up)
      return 1'b0;
    if (act | t.collision_blink_enable & p.collision)
      return w.blink_timebase_two;
    if (t.fast_speed_blink_enable & p.speed_fast | t.slow_speed_blink_enable & ~p.speed_fast)
      return w.blink_timebase_one;
    return st;
  endfunction

  // ----------------------------------------
  // bus master and helpers
  // ----------------------------------------
  task automatic axw(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s,
    output logic [1:0] rs);
    logic done;
    @(posedge ref_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    bready <= 1'b1;
    done = 1'b0;
    // no cycle limit here: only the watchdog ends a wait for the answer
    while (!done) begin
      @(posedge ref_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      done = bvalid;
    end
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic done;
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge ref_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      done = rvalid;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr_ctrl(input logic [15:0] v);
    axw(`LED0_CTRL_OFFSET, {16'hFFFF, v}, 4'hF, r);
    `CHK(r, `AXI_RESP_OKAY)
    axr(`LED0_CTRL_OFFSET, d, r);
    `CHK(d, {16'h0000, v})
    sh = led0_ctrl_t'(v);
  endtask

  task automatic step();
    phy_status_t q;
    q = phy_status_t'(8'($urandom));
    q.link_up = ($urandom % 5) != 0;
    if ($urandom % 4)
      q.link_check_state = 1'b0;
    @(posedge ref_clk);
    phy <= q;
    wave <= blink_wave_t'(2'($urandom));
    @(posedge ref_clk);
    #1;
    `CHK(led_on, exp_led(sh, phy, wave))
  endtask

  task automatic close_out();
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // the whole sequence needs about a thousand cycles
  initial begin
    #100000;
    n_errors++;
    close_out();
  end

  initial begin
    void'($urandom(76459));
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK(led_on, 1'b0)
    axr(`LED0_CTRL_OFFSET, d, r);
    `CHK(d, 32'h0000_0311)
    axr(16'h4100, d, r);
    `CHK(r, `AXI_RESP_SLVERR)
    axw(16'h4100, 32'h0000_FFFF, 4'hF, r);
    `CHK(r, `AXI_RESP_SLVERR)
    axw(`LED0_CTRL_OFFSET, 32'hFFFF_A5A5, 4'h1, r);
    axr(`LED0_CTRL_OFFSET, d, r);
    `CHK(d, 32'h0000_03A5)
    // first four settings walk every forced code
    for (i = 0; i < 24; i++) begin
      c = 16'($urandom);
      c[7:6] = 2'h0;
      if (i < 4)
        c[15:13] = {1'b1, i[1:0]};
      else if ($urandom % 3)
        c[15] = 1'b0;
      wr_ctrl(c);
      repeat (16) step();
    end
    wr_ctrl(16'hC000);
    @(posedge ref_clk);
    wave <= blink_wave_t'(2'b10);
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(led_on, 1'b1)
    @(posedge ref_clk);
    ce <= 1'b0;
    wave <= blink_wave_t'(2'b00);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK(led_on, 1'b1)
    @(posedge ref_clk);
    ce <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(led_on, 1'b0)
    @(posedge ref_clk);
    phy <= phy_status_t'(8'h20);
    wr_ctrl(16'h8000);
    axr(`LED0_STATUS_OFFSET, d, r);
    `CHK(d & 32'h19, 32'h18)
    axw(`LED0_STATUS_OFFSET, 32'hFFFF, 4'hF, r);
    `CHK(r, `AXI_RESP_OKAY)
    wr_ctrl(16'h8000);
    // activity stretch: one busy cycle must light the lamp for the whole hold
    for (k = 0; k < 2; k++) begin
      wr_ctrl(k ? 16'h0040 : 16'h0080);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(led_on, 1'b0)
      @(posedge ref_clk);
      phy <= phy_status_t'(k ? 8'h22 : 8'h24);
      @(posedge ref_clk);
      phy <= phy_status_t'(8'h20);
      repeat (HOLD - 3) @(posedge ref_clk);
      #1;
      `CHK(led_on, 1'b1)
      repeat (6) @(posedge ref_clk);
      #1;
      `CHK(led_on, 1'b0)
      `CHK(last_run >= HOLD, 1'b1)
    end
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(led_on, exp_led(led0_ctrl_t'(16'h0311), phy, wave))
    axr(`LED0_CTRL_OFFSET, d, r);
    `CHK(d, 32'h0000_0311)
    close_out();
  end
endmodule
